// file: usmr_regs.sv
// Status and mode-zero registers with receiver interrupt level and watchdog.
// Assumes a synchronous host bus on clk; mode_one bit 6 and core state come from clk logic.
`include "usmr_map.svh"
`default_nettype none
module usmr_regs (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              bus_addr,
    input  wire logic [7:0]              bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    input  wire logic                    mr_ptr_at_zero,
    input  wire usmr_pkg::usmr_enables_s core_enables,
    input  wire usmr_pkg::usmr_enhanced_s enhanced,
    input  wire logic                    mode_one_level,
    input  wire logic [8:0]              rx_count,
    input  wire logic                    rx_queue_read,
    input  wire logic                    rx_char_in,
    input  wire logic                    rx_bit_tick,
    input  wire logic                    echo_mode_req,
    input  wire logic                    rx_stop_sampled,
    input  wire logic                    tx_stop_done,
    output logic [7:0]                   bus_rdata,
    output logic [7:0]                   mode_zero,
    output logic                         rx_interrupt,
    output logic                         echo_active
);
    logic [7:0]           mode_zero_reg;
    logic [7:0]           mode_zero_next;
    logic [7:0]           rdata_reg;
    logic [7:0]           rdata_next;
    logic                 rx_int_reg;
    logic                 rx_int_next;
    logic                 level_hit;
    logic [8:0]           level;
    logic                 wd_fire;
    logic                 wd_restart;
    logic                 hit_mode_zero;
    usmr_pkg::usmr_echo_e echo_reg;
    usmr_pkg::usmr_echo_e echo_next;
    logic [7:0]           enable_word;
    logic [7:0]           enhanced_word;
    logic                 hit_enable_status;
    logic                 hit_enh_status;
    logic                 queue_has_data;
    logic                 echo_act_reg;
    logic                 echo_act_next;

    // Mode zero decode: direct address, or base address while the pointer selects it
    assign hit_mode_zero = (bus_addr == `USMR_ADDR_MODE_ZERO) ||
                           (bus_addr == `USMR_ADDR_MR_POINTER && mr_ptr_at_zero);

    // Status decodes; both registers are read-only, so writes to them fall through
    assign hit_enable_status = (bus_addr == `USMR_ADDR_ENABLE_STATUS);
    assign hit_enh_status    = (bus_addr == `USMR_ADDR_ENH_STATUS);
    assign queue_has_data    = (rx_count != 9'h000);

    // Enable status word from live core levels, so automatic receiver changes show at once
    always_comb
    begin
        enable_word    = 8'h00;
        enable_word[5] = core_enables.tx_enabled;
        enable_word[4] = core_enables.rx_enabled;
        enable_word[3] = mode_zero_reg[`USMR_MZ_WATCHDOG_BIT];
        enable_word[2] = core_enables.addr_recog;
        enable_word[1] = core_enables.xon_active;
        enable_word[0] = core_enables.xoff_active;
    end

    // Enhanced status word; unused and reserved positions read zero
    always_comb
    begin
        enhanced_word    = 8'h00;
        enhanced_word[6] = enhanced.io_port;
        enhanced_word[4] = enhanced.ct0_clock;
        enhanced_word[2] = enhanced.rxtx_clock;
        enhanced_word[0] = enhanced.fifo_level;
    end

    // Mode zero write acts at once on downstream logic
    always_comb
    begin
        mode_zero_next = mode_zero_reg;
        if (bus_wr && hit_mode_zero)
            mode_zero_next = bus_wdata;
    end

    // Read data mux
    always_comb
    begin
        rdata_next = rdata_reg;
        if (bus_rd)
        begin
            if (hit_enable_status)
                rdata_next = enable_word;
            else if (hit_enh_status)
                rdata_next = enhanced_word;
            else if (hit_mode_zero)
                rdata_next = mode_zero_reg;
            else
                rdata_next = 8'h00;
        end
    end

    // Fill-level threshold from the split level bits and depth select
    always_comb
    begin
        level = `USMR_LVL_SMALL_1;
        if (!mode_zero_reg[`USMR_MZ_DEPTH_BIT])
        begin
            case ({mode_zero_reg[`USMR_MZ_LEVEL_BIT], mode_one_level})
                2'b00:   level = `USMR_LVL_SMALL_1;
                2'b01:   level = `USMR_LVL_SMALL_3;
                2'b10:   level = `USMR_LVL_SMALL_6;
                2'b11:   level = `USMR_LVL_SMALL_8;
                default: level = `USMR_LVL_SMALL_1;
            endcase
        end
        else
        begin
            case ({mode_zero_reg[`USMR_MZ_LEVEL_BIT], mode_one_level})
                2'b00:   level = `USMR_LVL_SMALL_1;
                2'b01:   level = `USMR_LVL_BIG_128;
                default: level = `USMR_LVL_BIG_FULL;
            endcase
        end
    end

    assign level_hit  = (rx_count >= level);
    assign wd_restart = rx_queue_read || rx_char_in;

    // Receiver interrupt from level or watchdog
    always_comb
    begin
        rx_int_next = level_hit || wd_fire;
    end

    // Echo hand-back: hold echo until the transmitter stop bit is sent
    always_comb
    begin
        echo_next = echo_reg;
        case (echo_reg)
            usmr_pkg::USMR_ECHO_OFF:
                if (echo_mode_req)
                    echo_next = usmr_pkg::USMR_ECHO_ON;
            usmr_pkg::USMR_ECHO_ON:
                if (!echo_mode_req)
                begin
                    if (rx_stop_sampled && core_enables.tx_enabled)
                        echo_next = usmr_pkg::USMR_ECHO_HOLD;
                    else
                        echo_next = usmr_pkg::USMR_ECHO_OFF;
                end
            usmr_pkg::USMR_ECHO_HOLD:
                if (echo_mode_req)
                    echo_next = usmr_pkg::USMR_ECHO_ON;
                else if (tx_stop_done)
                    echo_next = usmr_pkg::USMR_ECHO_OFF;
            default:
                echo_next = usmr_pkg::USMR_ECHO_OFF;
        endcase
        echo_act_next = (echo_next != usmr_pkg::USMR_ECHO_OFF);
    end

    // Mode zero register; a write lands on the edge that takes it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mode_zero_reg <= `USMR_MODE_ZERO_RESET;
        else
            mode_zero_reg <= mode_zero_next;
    end

    // Read data register; holds until the next read strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // Receiver interrupt register; keeps the request free of decode glitches
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_int_reg <= 1'b0;
        else
            rx_int_reg <= rx_int_next;
    end

    // Echo state and its registered indication, so the output comes from a flop
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            echo_reg     <= usmr_pkg::USMR_ECHO_OFF;
            echo_act_reg <= 1'b0;
        end
        else
        begin
            echo_reg     <= echo_next;
            echo_act_reg <= echo_act_next;
        end
    end

    // Receiver watchdog
    usmr_watchdog u_watchdog (
        .clk      (clk),
        .reset_n  (reset_n),
        .enable   (mode_zero_reg[`USMR_MZ_WATCHDOG_BIT]),
        .bit_tick (rx_bit_tick),
        .restart  (wd_restart),
        .has_data (queue_has_data),
        .fire     (wd_fire)
    );

    assign bus_rdata    = rdata_reg;
    assign mode_zero    = mode_zero_reg;
    assign rx_interrupt = rx_int_reg;
    assign echo_active  = echo_act_reg;
endmodule : usmr_regs
`default_nettype wire

// file: usmr_map.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the top module of the status/mode block and by the watchdog.
// What this block does
// - Enable status reads transmitter bit 5, receiver bit 4, bits 7:6 zero.
// - Enable status bits 3..0 show watchdog, address recognition, Xon, Xoff.
// - Enable status reflects live state, including receiver automatic changes.
// - Enhanced status bits 6,4,2,0 show enhanced I/O, timer clock, Rx/Tx clock, FIFO level.
// - Enhanced status bits 3 and 1 read zero; 7 and 5 reserved.
// - Newly written modes take effect immediately, even mid character.
// - Leaving echo or loopback after stop sample: transmitter echoes until stop sent.
// - Mode zero reachable at its direct address and via pointer at base.
// - Mode zero bit 7 enables receiver interrupt after 64 idle bit times.
// - Receiver fill level chosen by mode zero bit 6 and mode one bit 6.
// - Receive queue empty after reset; default level interrupts at one byte.
// - Small queue levels 00,01,10,11 interrupt at 1, 3, 6, 8 bytes.
// - Mode zero bit 3 selects 8-byte or 256-byte queue depth.
`ifndef USMR_MAP_SVH
`define USMR_MAP_SVH
`define USMR_ADDR_ENH_STATUS   8'h12
`define USMR_ADDR_MODE_ZERO    8'h20
`define USMR_ADDR_ENABLE_STATUS 8'h40
`define USMR_ADDR_MR_POINTER   8'h00
`define USMR_MODE_ZERO_RESET   8'h00
`define USMR_MZ_WATCHDOG_BIT   7
`define USMR_MZ_LEVEL_BIT      6
`define USMR_MZ_DEPTH_BIT      3
`define USMR_WATCHDOG_BITS     7'h40
`define USMR_LVL_SMALL_1       9'h001
`define USMR_LVL_SMALL_3       9'h003
`define USMR_LVL_SMALL_6       9'h006
`define USMR_LVL_SMALL_8       9'h008
`define USMR_LVL_BIG_128       9'h080
`define USMR_LVL_BIG_FULL      9'h100
`endif

// file: usmr_pkg.sv
// Types shared by the status/mode register block.
// Assumes a single clock domain and the map header.
`default_nettype none
package usmr_pkg;
    // Live sub-system enables fed from the UART core
    typedef struct packed {
        logic tx_enabled;
        logic rx_enabled;
        logic addr_recog;
        logic xon_active;
        logic xoff_active;
    } usmr_enables_s;
    // Enhanced-operation indications
    typedef struct packed {
        logic io_port;
        logic ct0_clock;
        logic rxtx_clock;
        logic fifo_level;
    } usmr_enhanced_s;
    // Echo hand-back states
    typedef enum logic [2:0] {
        USMR_ECHO_OFF  = 3'b001,
        USMR_ECHO_ON   = 3'b010,
        USMR_ECHO_HOLD = 3'b100
    } usmr_echo_e;
endpackage : usmr_pkg
`default_nettype wire

// file: usmr_watchdog.sv
// Receiver watchdog: counts 1x bit-time enables while the queue is idle.
// Assumes bit_tick is a one-cycle enable on clk and restart comes from clk logic.
`include "usmr_map.svh"
`default_nettype none
module usmr_watchdog (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic bit_tick,
    input  wire logic restart,
    input  wire logic has_data,
    output logic      fire
);
    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic       fire_reg;
    logic       fire_next;

    // Idle counter and sticky timeout until next access
    always_comb
    begin
        count_next = count_reg;
        fire_next  = fire_reg;
        if (!enable || restart || !has_data)
        begin
            count_next = 7'h00;
            fire_next  = 1'b0;
        end
        else if (bit_tick && !fire_reg)
        begin
            count_next = count_reg + 7'h01;
            if (count_next == `USMR_WATCHDOG_BITS)
                fire_next = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= 7'h00;
            fire_reg  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            fire_reg  <= fire_next;
        end
    end

    assign fire = fire_reg;
endmodule : usmr_watchdog
`default_nettype wire

// file: usmr_regs_asserts.sv
// Checker for the status/mode register block, bound to usmr_regs.
// Assumes one clock domain and the package compiled first.
`default_nettype none
module usmr_regs_asserts (
    input wire logic                     clk,
    input wire logic                     reset_n,
    input wire logic                     bus_wr,
    input wire logic                     bus_rd,
    input wire logic                     mr_ptr_at_zero,
    input wire logic                     mode_one_level,
    input wire logic                     rx_queue_read,
    input wire logic                     rx_char_in,
    input wire logic                     rx_bit_tick,
    input wire logic                     echo_mode_req,
    input wire logic                     rx_stop_sampled,
    input wire logic                     rx_interrupt,
    input wire logic                     echo_active,
    input wire logic [7:0]               bus_addr,
    input wire logic [7:0]               bus_wdata,
    input wire logic [7:0]               bus_rdata,
    input wire logic [7:0]               mode_zero,
    input wire logic [8:0]               rx_count,
    input wire usmr_pkg::usmr_enables_s  core_enables,
    input wire usmr_pkg::usmr_enhanced_s enhanced
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [8:0] thr;
    logic [6:0] wd_cnt, wd_next;
    logic       restart;
    // Fill threshold from depth and the split level code
    always_comb
    begin
        case ({mode_zero[3], mode_zero[6], mode_one_level})
            3'h0, 3'h4: thr = 9'h001;
            3'h1: thr = 9'h003;
            3'h2: thr = 9'h006;
            3'h3: thr = 9'h008;
            3'h5: thr = 9'h080;
            default: thr = 9'h100;
        endcase
    end
    // Idle bit times counted while data waits unread
    assign restart = !mode_zero[7] || rx_count == 9'h000 || rx_queue_read || rx_char_in;
    always_comb
    begin
        wd_next = wd_cnt;
        if (restart)
            wd_next = 7'h00;
        else if (rx_bit_tick && wd_cnt < 7'h40)
            wd_next = wd_cnt + 7'h01;
    end
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            wd_cnt <= 7'h00;
        else
            wd_cnt <= wd_next;
    a_enable_read:
        assert property (bus_rd && bus_addr == 8'h40 |=> bus_rdata == $past({2'h0,
            core_enables[4:3], mode_zero[7], core_enables[2:0]})) else $error("Bad enables");
    a_enhanced_read:
        assert property (bus_rd && bus_addr == 8'h12 |=> bus_rdata == $past({1'b0, enhanced[3],
            1'b0, enhanced[2], 1'b0, enhanced[1], 1'b0, enhanced[0]})) else $error("Bad enhanced");
    a_mode_write:
        assert property (bus_wr && (bus_addr == 8'h20 || bus_addr == 8'h00 && mr_ptr_at_zero)
            |=> mode_zero == $past(bus_wdata)) else $error("Mode write lost");
    a_fill_level:
        assert property (!mode_zero[7] && !$past(mode_zero[7])
            |=> rx_interrupt == $past(rx_count >= thr)) else $error("Bad fill level");
    a_wdog_fire:
        assert property ((wd_cnt == 7'h40 && !restart) [*3] |-> rx_interrupt)
            else $error("Watchdog silent");
    a_echo_enter:
        assert property ($rose(echo_mode_req) |=> echo_active) else $error("Echo late");
    a_echo_hold:
        assert property ($fell(echo_mode_req) && rx_stop_sampled && core_enables.tx_enabled
            |=> echo_active) else $error("Echo cut short");
    a_echo_drop:
        assert property ($fell(echo_mode_req) && !rx_stop_sampled |=> !echo_active)
            else $error("Echo stuck");
    c_wdog: cover property (wd_cnt == 7'h40 && rx_interrupt);
    c_hold: cover property (echo_active && !echo_mode_req);
    c_full: cover property (rx_interrupt && rx_count == 9'h100);
endmodule : usmr_regs_asserts
bind usmr_regs usmr_regs_asserts u_chk (
    .clk             (clk),
    .reset_n         (reset_n),
    .bus_wr          (bus_wr),
    .bus_rd          (bus_rd),
    .mr_ptr_at_zero  (mr_ptr_at_zero),
    .mode_one_level  (mode_one_level),
    .rx_queue_read   (rx_queue_read),
    .rx_char_in      (rx_char_in),
    .rx_bit_tick     (rx_bit_tick),
    .echo_mode_req   (echo_mode_req),
    .rx_stop_sampled (rx_stop_sampled),
    .rx_interrupt    (rx_interrupt),
    .echo_active     (echo_active),
    .bus_addr        (bus_addr),
    .bus_wdata       (bus_wdata),
    .bus_rdata       (bus_rdata),
    .mode_zero       (mode_zero),
    .rx_count        (rx_count),
    .core_enables    (core_enables),
    .enhanced        (enhanced)
);
`default_nettype wire

// file: usmr_host.sv
// Host processor model: single byte accesses on the register bus.
// Assumes the bench clock; lines change 1 ns after a rising edge.
`default_nettype none
module usmr_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            wr,
    output logic            rd,
    output logic [7:0]      addr,
    output logic [7:0]      wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {wr, rd, addr, wdata} = 18'h0_0000;
    // Whole one-cycle strobe; strobes then drop to zero, address and data lines turn to their inverse
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk);
        #1;
        {wr, rd, addr, wdata} = {w, !w, a, d};
        @(posedge clk);
        #1;
        {wr, rd} = 2'h0;
        addr = ~addr;
        wdata = ~wdata;
        q = rdata;
    endtask : access
endmodule : usmr_host
`default_nettype wire

// file: usmr_regs_bench.sv
// Self-checking bench for the status/mode register block.
// Assumes package, design, checker and host model compiled first.
`default_nettype none
module usmr_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, wr, rd, ptr, m1, rq, ci, tick, echo, stop, done, irq, eact;
    logic [7:0] addr, wdata, rdata, mz, q, d, exp_mz;
    logic [8:0] cnt;
    logic [7:0] wtab [5] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h12};
    usmr_pkg::usmr_enables_s en;
    usmr_pkg::usmr_enhanced_s eh;
    int n_fail, tests_run;
    usmr_regs dut (.clk(clk), .reset_n(reset_n), .bus_addr(addr), .bus_wdata(wdata),
        .bus_wr(wr), .bus_rd(rd), .mr_ptr_at_zero(ptr), .core_enables(en), .enhanced(eh),
        .mode_one_level(m1), .rx_count(cnt), .rx_queue_read(rq), .rx_char_in(ci),
        .rx_bit_tick(tick), .echo_mode_req(echo), .rx_stop_sampled(stop),
        .tx_stop_done(done), .bus_rdata(rdata), .mode_zero(mz), .rx_interrupt(irq),
        .echo_active(eact));
    usmr_host host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    function automatic int thr(input logic dp, l0, l1);
        int t [8] = '{1, 3, 6, 8, 1, 128, 256, 256};
        return t[{dp, l0, l1}];
    endfunction : thr
    task automatic chk(input logic [8:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #20000;
        n_fail++;
        results();
    end
    initial
    begin
        {reset_n, ptr, m1, rq, ci, tick, echo, stop, done, en, eh, cnt} = '0;
        void'($urandom(32'hf692_3669));
        step(12);
        reset_n = 1'b1;
        chk(irq, 1'b0);
        // Status reads follow live core levels
        repeat (8)
        begin
            {en, eh} = 9'($urandom);
            host.access(1'b0, 8'h40, 8'h00, q);
            chk(q, {2'h0, en[4:3], 1'b0, en[2:0]});
            host.access(1'b0, 8'h12, 8'h00, q);
            chk(q, {1'b0, eh[3], 1'b0, eh[2], 1'b0, eh[1], 1'b0, eh[0]});
        end
        host.access(1'b0, 8'h55, 8'h00, q);
        chk(q, 8'h00);
        $display("Status test done");
        // Direct, pointer and refused writes
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($urandom);
            ptr = (i == 1);
            host.access(1'b1, wtab[i], d, q);
            if (i < 2)
                exp_mz = d;
            chk(mz, exp_mz);
        end
        $display("Write test done");
        // Every depth and level code, one below and at the threshold
        for (int c = 0; c < 8; c++)
        begin
            m1 = c[0];
            host.access(1'b1, 8'h20, {1'b0, c[1], 2'h0, c[2], 3'h0}, q);
            for (int k = -1; k < 1; k++)
            begin
                cnt = 9'(thr(c[2], c[1], c[0]) + k);
                step(2);
                chk(irq, k == 0);
            end
        end
        $display("Level test done");
        // Watchdog with two bytes held under the full level
        host.access(1'b1, 8'h20, 8'hc0, q);
        cnt = 9'h002;
        host.access(1'b0, 8'h40, 8'h00, q);
        chk(q[3], 1'b1);
        // Three spans one tick short, restarted by a character then by reads; then a full span
        for (int r = 0; r < 4; r++)
        begin
            repeat (63 + (r == 3))
            begin
                tick = 1'b1;
                step(1);
                tick = 1'b0;
                step(1);
            end
            step(3);
            chk(irq, r == 3);
            if (r == 0)
                ci = 1'b1;
            else
                rq = 1'b1;
            step(1);
            {rq, ci} = 2'h0;
        end
        step(2);
        chk(irq, 1'b0);
        $display("Watchdog test done");
        // Echo entry, hand-back hold and plain exit
        en = 5'h10;
        echo = 1'b1;
        step(1);
        chk(eact, 1'b1);
        {echo, stop} = 2'h1;
        step(1);
        stop = 1'b0;
        step(3);
        chk(eact, 1'b1);
        done = 1'b1;
        step(1);
        done = 1'b0;
        step(2);
        chk(eact, 1'b0);
        echo = 1'b1;
        step(2);
        echo = 1'b0;
        step(1);
        chk(eact, 1'b0);
        $display("Echo test done");
        results();
    end
endmodule : usmr_regs_bench
`default_nettype wire
